// File: include/timer_params.svh
// Register offsets, control bit positions, reset values and divider ratios
// for the sixteen-bit timer. Included by the RTL and the bench.
// Offsets are word indices: the bus byte address is four times the index.
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

`define TMR_OFS_CNT_HI 8'hE4
`define TMR_OFS_CNT_LO 8'hE5
`define TMR_OFS_REF_HI 8'hE6
`define TMR_OFS_REF_LO 8'hE7
`define TMR_OFS_CTRL 8'hE8
`define TMR_OFS_IRQ_STAT 8'hF0
`define TMR_OFS_IRQ_EN 8'hF4
`define TMR_OFS_IRQ_CLR 8'hF8

`define TMR_CTRL_PEND 0
`define TMR_CTRL_MCIE 1
`define TMR_CTRL_OVIE 2
`define TMR_CTRL_CLR 3
`define TMR_CTRL_EDGE_LO 4
`define TMR_CTRL_EDGE_HI 5
`define TMR_CTRL_CKS_LO 6
`define TMR_CTRL_CKS_HI 7
`define TMR_CTRL_RESET 8'h00

`define TMR_DIV4 4
`define TMR_DIV8 8
`define TMR_DIV16 16
`define TMR_AXI_OKAY 2'h0
`define TMR_AXI_SLVERR 2'h2

`endif

// File: include/timer_pkg.sv
// Types shared by the sixteen-bit timer: clock source, edge select, control.
// Assumes the params header is on the include path.
package timer_pkg;
    typedef enum logic [1:0] {
        CKS_DIV4 = 2'b00,
        CKS_DIV8 = 2'b01,
        CKS_DIV16 = 2'b10,
        CKS_CNTA = 2'b11
    } clk_sel_t;

    typedef enum logic [1:0] {
        EDGE_RISE = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_BOTH = 2'b10,
        EDGE_BOTH2 = 2'b11
    } edge_sel_t;

    // Control fields other than the pending flag and the clear strobe
    typedef struct packed {
        logic capture_mode;
        clk_sel_t clk_sel;
        edge_sel_t edge_sel;
        logic overflow_ie;
        logic match_ie;
    } ctrl_t;
endpackage : timer_pkg

// File: rtl/timer_16bit_match_capture.sv
// Sixteen-bit up timer with overflow, match and capture, AXI4-Lite slave.
// Assumes one 40 MHz clock, inputs synchronous to it, software as master.
// Functional notes
// - Timer tick is osc/4, /8, /16 or the companion counter flip-flop.
// - Overflow request raised at count FFFF when overflow enable is set.
// - After overflow the count wraps to zero and keeps counting.
// - Writing one to control bit 3 clears the count at once.
// - Match mode: count equal to reference raises interrupt, clears count.
// - Capture mode: selected trigger edge raises match/capture request.
// - Control bits 5:4 select rising, falling or both capture edges.
// - Control bit 0 is pending flag, read one, cleared by writing zero.
// - Separate match/capture interrupt enable, independent of overflow.
// - Overflow request has priority over match/capture request.
// - Reset clears control: divide by four, interval mode, irqs off.
// - Count readable as two read-only bytes; reference bytes read/write.
`include "timer_params.svh"
`timescale 1ns/10ps
`default_nettype none

module timer_16bit_match_capture
    import timer_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic cnta_ff,
    input wire logic capture_in,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic ovf_req,
    output logic mc_req,
    output logic irq
);
    localparam int DIVW = 4;

    ctrl_t ctrl_r;
    logic pend_r;
    logic [CNT_W-1:0] cnt_r;
    logic [7:0] ref_hi_r;
    logic [7:0] ref_lo_r;
    logic [3:0] div_r;
    logic cnta_d_r;
    logic cap_s1_r;
    logic cap_s2_r;
    logic cap_d_r;
    logic [1:0] ist_r;
    logic [1:0] ien_r;
    logic tick;
    logic cap_evt;
    logic ovf_evt;
    logic match_evt;
    logic mc_evt;
    logic cnt_clr;
    logic [CNT_W-1:0] ref_val;
    logic [15:0] cnt16;
    logic [1:0] edge_code;

    // AXI write side
    logic [7:0] awaddr_r;
    logic aw_have_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_have_r;
    logic wr_go;
    logic [7:0] wb;

    // Byte views stay 16 bits; a narrow counter matches the low ref bits
    assign ref_val = CNT_W'({ref_hi_r, ref_lo_r});
    assign cnt16 = 16'(cnt_r);
    assign edge_code = 2'(ctrl_r.edge_sel + 2'h1);

    // Tick from prescaler or companion flip-flop rising edge
    always_comb begin
        unique case (ctrl_r.clk_sel)
            CKS_DIV4: tick = (div_r[1:0] == 2'b11);
            CKS_DIV8: tick = (div_r[2:0] == 3'b111);
            CKS_DIV16: tick = (div_r == 4'hF);
            CKS_CNTA: tick = cnta_ff & ~cnta_d_r;
        endcase
    end

    // Free-running prescaler; always runs so the ratio change is glitch free
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_r <= 4'h0;
            cnta_d_r <= 1'b0;
        end else if (clk_en) begin
            div_r <= div_r + 4'h1;
            cnta_d_r <= cnta_ff;
        end
    end

    // Capture input: two-flop sync, edge seen only on ticks
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cap_s1_r <= 1'b0;
            cap_s2_r <= 1'b0;
            cap_d_r <= 1'b0;
        end else if (clk_en) begin
            cap_s1_r <= capture_in;
            cap_s2_r <= cap_s1_r;
            if (tick)
                cap_d_r <= cap_s2_r;
        end
    end

    // Edge qualification per selected trigger
    always_comb begin
        unique case (ctrl_r.edge_sel)
            EDGE_RISE: cap_evt = cap_s2_r & ~cap_d_r;
            EDGE_FALL: cap_evt = ~cap_s2_r & cap_d_r;
            EDGE_BOTH, EDGE_BOTH2: cap_evt = cap_s2_r ^ cap_d_r;
        endcase
        cap_evt = cap_evt & tick & ctrl_r.capture_mode;
    end

    assign ovf_evt = tick & (cnt_r == {CNT_W{1'b1}});
    assign match_evt = tick & ~ctrl_r.capture_mode & (cnt_r == ref_val);
    assign mc_evt = match_evt | cap_evt;
    assign cnt_clr = wr_go && awaddr_r == `TMR_OFS_CTRL && wstrb_r[0]
        && wdata_r[`TMR_CTRL_CLR];

    // Counter: software clear, match clear, wrap at all ones
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cnt_r <= '0;
        end else if (clk_en) begin
            if (cnt_clr)
                cnt_r <= '0;
            else if (match_evt)
                cnt_r <= '0;
            else if (tick)
                cnt_r <= cnt_r + 1'b1; // wraps FFFF to 0
        end
    end

    // Pending flag: hardware set wins over software clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pend_r <= 1'b0;
        end else if (clk_en) begin
            if (mc_evt)
                pend_r <= 1'b1;
            else if (wr_go && awaddr_r == `TMR_OFS_CTRL && wstrb_r[0]
                     && !wdata_r[`TMR_CTRL_PEND])
                pend_r <= 1'b0;
        end
    end

    // Control and reference registers; capture overrides reference writes
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_r <= ctrl_t'(7'h00);
            ref_hi_r <= 8'h00;
            ref_lo_r <= 8'h00;
        end else if (clk_en) begin
            if (wr_go && wstrb_r[0]) begin
                // Bits 7:6 pick the source; edge code 00 means interval mode
                if (awaddr_r == `TMR_OFS_CTRL)
                    ctrl_r <= '{capture_mode: |wb[5:4],
                        clk_sel: clk_sel_t'(wb[7:6]),
                        edge_sel: edge_sel_t'(wb[5:4] - 2'h1),
                        overflow_ie: wb[2], match_ie: wb[1]};
                if (awaddr_r == `TMR_OFS_REF_HI)
                    ref_hi_r <= wb;
                if (awaddr_r == `TMR_OFS_REF_LO)
                    ref_lo_r <= wb;
            end
            if (cap_evt) begin
                ref_hi_r <= cnt16[15:8];
                ref_lo_r <= cnt16[7:0];
            end
        end
    end
    assign wb = wdata_r[7:0];

    // Requests; overflow masks match/capture request while both pend
    assign ovf_req = ctrl_r.overflow_ie & ist_r[0];
    assign mc_req = ctrl_r.match_ie & pend_r & ~ovf_req;

    // Sticky status: bit0 overflow, bit1 match/capture; set wins
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ist_r <= 2'b00;
            ien_r <= 2'b00;
        end else if (clk_en) begin
            if (wr_go && wstrb_r[0] && awaddr_r == `TMR_OFS_IRQ_EN)
                ien_r <= wb[1:0];
            ist_r <= (ist_r & ~((wr_go && wstrb_r[0] &&
                awaddr_r == `TMR_OFS_IRQ_CLR) ? wb[1:0] : 2'b00))
                | {mc_evt, ovf_evt};
        end
    end
    assign irq = |(ist_r & ien_r);

    // Write channel capture; address and data may come in either order
    // No handshake offered while frozen, or it would be lost
    assign s_axi_awready = clk_en & ~aw_have_r & ~s_axi_bvalid;
    assign s_axi_wready = clk_en & ~w_have_r & ~s_axi_bvalid;
    assign wr_go = aw_have_r & w_have_r & ~s_axi_bvalid;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TMR_AXI_OKAY;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr[9:2]; // Word index
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                unique case (awaddr_r)
                    `TMR_OFS_REF_HI, `TMR_OFS_REF_LO, `TMR_OFS_CTRL,
                    `TMR_OFS_IRQ_EN, `TMR_OFS_IRQ_CLR:
                        s_axi_bresp <= `TMR_AXI_OKAY;
                    default: s_axi_bresp <= `TMR_AXI_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read channel; one-cycle answer after address taken
    assign s_axi_arready = clk_en & ~s_axi_rvalid;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `TMR_AXI_OKAY;
        end else if (clk_en) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `TMR_AXI_OKAY;
                unique case (s_axi_araddr[9:2])
                    `TMR_OFS_CNT_HI: s_axi_rdata <= {24'h0, cnt16[15:8]};
                    `TMR_OFS_CNT_LO: s_axi_rdata <= {24'h0, cnt16[7:0]};
                    `TMR_OFS_REF_HI: s_axi_rdata <= {24'h0, ref_hi_r};
                    `TMR_OFS_REF_LO: s_axi_rdata <= {24'h0, ref_lo_r};
                    `TMR_OFS_CTRL: s_axi_rdata <= {24'h0, ctrl_r.clk_sel,
                        ctrl_r.capture_mode ? edge_code : 2'h0, 1'b0,
                        ctrl_r.overflow_ie, ctrl_r.match_ie, pend_r};
                    `TMR_OFS_IRQ_STAT: s_axi_rdata <= {30'h0, ist_r};
                    `TMR_OFS_IRQ_EN: s_axi_rdata <= {30'h0, ien_r};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= `TMR_AXI_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    AST_OVF_WRAP: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && ovf_evt && !cnt_clr |=> cnt_r == '0)
        else $error("count did not wrap after overflow");
    AST_MATCH_CLR: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && match_evt |=> cnt_r == '0 && pend_r)
        else $error("match did not clear count or set pending");
    AST_SW_CLR: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && cnt_clr |=> cnt_r == '0)
        else $error("software clear ignored");
    AST_OVF_REQ: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && ovf_evt && ctrl_r.overflow_ie |=> ovf_req)
        else $error("overflow request missing");
    AST_PRIO: assert property (@(posedge clk) disable iff (sys_rst)
        ovf_req |-> !mc_req)
        else $error("match request beside overflow request");
    AST_CAP_LATCH: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && cap_evt |=> ref_val == $past(cnt_r))
        else $error("capture value not latched");
    AST_PEND_SET: assert property (@(posedge clk) disable iff (sys_rst)
        clk_en && cap_evt |=> pend_r)
        else $error("capture did not set pending");
    AST_CAP_MODE: assert property (@(posedge clk) disable iff (sys_rst)
        !ctrl_r.capture_mode |-> !cap_evt)
        else $error("capture event outside capture mode");
    AST_RESET_CTRL: assert property (@(posedge clk)
        sys_rst |=> ctrl_r == ctrl_t'(7'h00) && !irq)
        else $error("control not cleared by reset");
    COV_OVF: cover property (@(posedge clk) disable iff (sys_rst) ovf_evt);
    COV_MATCH: cover property (@(posedge clk) disable iff (sys_rst)
        match_evt);
    COV_CAP: cover property (@(posedge clk) disable iff (sys_rst) cap_evt);
endmodule : timer_16bit_match_capture

`default_nettype wire

// File: tb/timer_16bit_match_capture_tb.sv
// Self-checking bench for the sixteen-bit timer over AXI4-Lite.
// Assumes the params header on the include path and the pin model.
`include "timer_params.svh"
`timescale 1ns/10ps
`default_nettype none
module timer_16bit_match_capture_tb;
    localparam int CW = 8; // Short counter keeps overflow runs brief
    localparam int LIMIT = 20000;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    wire logic capture_in;
    wire logic cnta_ff;
    logic [9:0] awaddr = 10'h000;
    logic [9:0] araddr = 10'h000;
    logic [1:0] rr, br;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ovf_req, mc_req, irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, rv, cap;
    logic [7:0] ref8, c8;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    int seed;

    always #12.5 clk = ~clk;

    timer_16bit_match_capture #(.CNT_W(CW)) i_timer_16bit_match_capture (
        .clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .cnta_ff(cnta_ff),
        .capture_in(capture_in), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ovf_req(ovf_req), .mc_req(mc_req), .irq(irq)
    );

    trigger_pin_model i_trigger_pin_model (
        .clk(clk), .capture_in(capture_in), .cnta_ff(cnta_ff)
    );

    // Hang guard: a stuck handshake ends the run as a failure
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rng(input logic [31:0] v, input int lo, input int hi);
        chk(32'(v >= 32'(lo) && v <= 32'(hi)), 32'h1);
    endtask : rng

    // Handshakes judged mid-cycle, acted on at the next rising edge
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= {a, 2'b00};
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            br = bresp;
            @(posedge clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
        end while (!tb);
        bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [7:0] a);
        logic ta, tr;
        @(posedge clk);
        araddr <= {a, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = arvalid & arready;
            tr = rvalid;
            rv = rdata;
            rr = rresp;
            @(posedge clk);
            if (ta) arvalid <= 1'b0;
        end while (!tr);
        rready <= 1'b0;
    endtask : axr

    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        axr(a);
        chk(rv, e);
    endtask : rdx

    // Bounded poll of one register bit until it reads one
    task automatic poll(input logic [7:0] a, input int b);
        for (int k = 0; k < 400; k++) begin
            axr(a);
            if (rv[b] === 1'b1) break;
        end
        chk(32'(rv[b]), 32'h1);
    endtask : poll

    function automatic logic [31:0] cap_hit(input int e, input logic up);
        return 32'(up ? e != 1 : e != 0);
    endfunction : cap_hit

    // Clocks per tick for each source; the model's flip-flop repeats in 14
    function automatic int tick_period(input int d);
        case (d)
            0: return `TMR_DIV4;
            1: return `TMR_DIV8;
            2: return `TMR_DIV16;
            default: return 14;
        endcase
    endfunction : tick_period

    initial begin
        seed = $urandom(32'hC6121D48);
        ref8 = 8'($urandom_range(40, 12));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk(32'({ovf_req, mc_req, irq}), 32'h0);
        rdx(`TMR_OFS_CTRL, 32'h0);
        rdx(8'hC0, 32'h0);
        chk(32'(rr), 32'(`TMR_AXI_SLVERR));
        axw(`TMR_OFS_REF_HI, 32'h0);
        axw(`TMR_OFS_REF_LO, 32'(ref8));
        chk(32'(br), 32'(`TMR_AXI_OKAY));
        rdx(`TMR_OFS_REF_LO, 32'(ref8));
        axw(`TMR_OFS_CNT_HI, 32'hFF);
        chk(32'(br), 32'(`TMR_AXI_SLVERR));
        rdx(`TMR_OFS_CNT_HI, 32'h0);
        // Match: flag, request, interrupt mask and clear
        axw(`TMR_OFS_IRQ_EN, 32'h3);
        axw(`TMR_OFS_CTRL, 32'h02);
        poll(`TMR_OFS_CTRL, 0);
        axr(`TMR_OFS_CNT_LO);
        rng(rv, 0, ref8);
        @(negedge clk);
        chk(32'({mc_req, irq}), 32'h3);
        axw(`TMR_OFS_REF_HI, 32'hFF);
        // Park the match at all ones so none races the clear checks
        axw(`TMR_OFS_REF_LO, 32'hFF);
        axw(`TMR_OFS_IRQ_EN, 32'h0);
        @(negedge clk);
        chk(32'(irq), 32'h0);
        axw(`TMR_OFS_IRQ_EN, 32'h3);
        axw(`TMR_OFS_CTRL, 32'h02);
        axw(`TMR_OFS_IRQ_CLR, 32'h3);
        @(negedge clk);
        chk(32'({mc_req, irq}), 32'h0);
        // Clear strobe then tick rate for every clock source
        for (int d = 0; d < 4; d++) begin
            axw(`TMR_OFS_CTRL, 32'(d << 6) | 32'h08);
            repeat (80) @(posedge clk);
            axr(`TMR_OFS_CNT_LO);
            rng(rv, 80 / tick_period(d), 84 / tick_period(d) + 1);
        end
        // Frozen enable stops the count
        c8 = rv[7:0];
        clk_en <= 1'b0;
        repeat (60) @(posedge clk);
        clk_en <= 1'b1;
        axr(`TMR_OFS_CNT_LO);
        rng(32'(rv[7:0] - c8), 0, 3);
        // Overflow, wrap, then priority over a capture
        axw(`TMR_OFS_CTRL, 32'h0C);
        axw(`TMR_OFS_IRQ_CLR, 32'h3);
        poll(`TMR_OFS_IRQ_STAT, 0);
        axr(`TMR_OFS_CNT_LO);
        rng(rv, 0, 8);
        @(negedge clk);
        chk(32'(ovf_req), 32'h1);
        axw(`TMR_OFS_CTRL, 32'h36);
        i_trigger_pin_model.put_level(1'b1);
        @(negedge clk);
        chk(32'({ovf_req, mc_req}), 32'h2);
        axw(`TMR_OFS_IRQ_CLR, 32'h1);
        @(negedge clk);
        chk(32'({ovf_req, mc_req}), 32'h1);
        @(posedge clk);
        i_trigger_pin_model.put_level(1'b0);
        // Each edge select against both pin edges
        for (int e = 0; e < 3; e++) begin
            axw(`TMR_OFS_CTRL, 32'h02 | 32'((e + 1) << 4));
            i_trigger_pin_model.put_level(1'b1);
            axr(`TMR_OFS_CTRL);
            chk(32'(rv[0]), cap_hit(e, 1'b1));
            if (e == 0) begin
                axr(`TMR_OFS_REF_LO);
                cap = rv;
                axr(`TMR_OFS_CNT_LO);
                rng(32'(rv[7:0] - cap[7:0]), 8, 20);
            end
            axw(`TMR_OFS_CTRL, 32'h02 | 32'((e + 1) << 4));
            i_trigger_pin_model.put_level(1'b0);
            axr(`TMR_OFS_CTRL);
            chk(32'(rv[0]), cap_hit(e, 1'b0));
        end
        close_out();
    end
endmodule : timer_16bit_match_capture_tb
`default_nettype wire

// File: tb/trigger_pin_model.sv
// Far side model: capture trigger pin and companion counter flip-flop.
// Assumes put_level is called just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module trigger_pin_model (
    input wire logic clk,
    output logic capture_in,
    output logic cnta_ff
);
    int div_q = 0;
    initial begin
        capture_in = 1'b0;
        cnta_ff = 1'b0;
    end
    // Flip-flop toggles much slower than clk
    always @(posedge clk) begin
        div_q <= (div_q + 1) % 7;
        if (div_q == 0) cnta_ff <= ~cnta_ff;
    end
    // Level held far past two ticks so each edge is seen once
    task automatic put_level(input logic v);
        capture_in <= v;
        repeat (40) @(posedge clk);
    endtask : put_level
endmodule : trigger_pin_model
`default_nettype wire
